// *** common/camd_pkg.sv ***
// Purpose: constants and types for the addressing mode decoder
// Assumes: 8-bit core, 16-bit address space, 10 MHz core_clk
// Notes: opcode layout is mode[7:4], index select [3], operation [2:0]
package camd_pkg;
    // ****************************************
    // opcode fields
    // ****************************************
    localparam int CAMD_MODE_MSB = 7;
    localparam int CAMD_MODE_LSB = 4;
    localparam int CAMD_IDX_SEL_BIT = 3;
    localparam int CAMD_OP_MSB = 2;

    localparam logic [3:0] CAMD_M_INH = 4'h0;
    localparam logic [3:0] CAMD_M_IMM = 4'h1;
    localparam logic [3:0] CAMD_M_DIR_S = 4'h2;
    localparam logic [3:0] CAMD_M_DIR_L = 4'h3;
    localparam logic [3:0] CAMD_M_IDX_N = 4'h4;
    localparam logic [3:0] CAMD_M_IDX_S = 4'h5;
    localparam logic [3:0] CAMD_M_IDX_L = 4'h6;
    localparam logic [3:0] CAMD_M_IND_S = 4'h7;
    localparam logic [3:0] CAMD_M_IND_L = 4'h8;

    localparam logic [2:0] CAMD_OP_HALT = 3'h1;
    localparam logic [2:0] CAMD_OP_INT_EN = 3'h2;
    localparam logic [2:0] CAMD_OP_INT_DIS = 3'h3;
    localparam logic [2:0] CAMD_OP_JRLE = 3'h7;

    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [15:0] CAMD_PC_RST = 16'h0000;
    localparam logic [1:0] CAMD_LVL0 = 2'h2;
    localparam logic [1:0] CAMD_LVL3 = 2'h3;
    localparam logic [1:0] CAMD_MASK_RST = 2'h3;

    typedef enum logic [2:0] {
        CAMD_S_OPC, CAMD_S_OP1, CAMD_S_OP2, CAMD_S_PT1, CAMD_S_PT2, CAMD_S_EXEC, CAMD_S_HALT
    } camd_state_t;
endpackage

// *** common/camd_ea_if.sv ***
// Purpose: carries operand and index values to the address adder
// Assumes: one clock, purely combinational path
// Notes: ea is valid whenever the inputs are stable
`timescale 1ns/1ps
interface camd_ea_if;
    logic [3:0] mode;
    logic idx_y;
    logic [7:0] x;
    logic [7:0] y;
    logic [15:0] operand;
    logic [15:0] ea;
    modport core (output mode, output idx_y, output x, output y, output operand, input ea);
    modport calc (input mode, input idx_y, input x, input y, input operand, output ea);
endinterface

// *** rtl/camd_ea_calc.sv ***
// Purpose: effective address former for all addressing modes
// Assumes: operand holds the assembled offset, address or pointer word
// Notes: combinational, no state
`timescale 1ns/1ps
module camd_ea_calc
    import camd_pkg::*;
(
    camd_ea_if.calc eab
);
    logic [7:0] idx;

    // ****************************************
    // address sum
    // ****************************************
    // index selection, opcode bit picks Y over X
    assign idx = eab.idx_y ? eab.y : eab.x;

    always_comb begin
        case (eab.mode)
            CAMD_M_IDX_N: eab.ea = {8'h00, idx};
            CAMD_M_IDX_S: eab.ea = {8'h00, idx} + {8'h00, eab.operand[7:0]};
            CAMD_M_IDX_L: eab.ea = {8'h00, idx} + eab.operand;
            CAMD_M_DIR_S, CAMD_M_IND_S: eab.ea = {8'h00, eab.operand[7:0]};
            default: eab.ea = eab.operand;
        endcase
    end
endmodule

// *** rtl/camd_core.sv ***
// Purpose: fetch and decode of one instruction, effective address, mask, halt
// Assumes: memory answers a held read with mem_ack, data valid on that cycle
// Notes: index and flag inputs come from core logic on core_clk
`timescale 1ns/1ps
module camd_core
    import camd_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic [7:0] idx_x,
    input wire logic [7:0] idx_y,
    input wire logic carry_flag,
    input wire logic zero_flag,
    input wire logic wake_req,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic [15:0] pc,
    output logic [7:0] opcode,
    output logic [15:0] operand,
    output logic [15:0] eff_addr,
    output logic [1:0] instr_len,
    output logic instr_done,
    output logic [1:0] interrupt_mask_level,
    output logic branch_taken,
    output logic osc_stop
);
    camd_state_t state_r;
    logic [15:0] pc_r, addr_r, operand_r, ea_r;
    logic [7:0] opcode_r, ptr_r;
    logic [1:0] len_r, mask_r;
    logic rd_r, done_r, taken_r, stop_r, wake_s1_r, wake_s2_r;
    logic [3:0] mode;
    logic [2:0] op;
    logic inh_int_en, inh_int_dis, inh_halt, is_jrle;
    camd_ea_if eab ();

    assign mode = opcode_r[CAMD_MODE_MSB:CAMD_MODE_LSB];
    assign op = opcode_r[CAMD_OP_MSB:0];
    assign inh_int_en = (mode == CAMD_M_INH) && (op == CAMD_OP_INT_EN);
    assign inh_int_dis = (mode == CAMD_M_INH) && (op == CAMD_OP_INT_DIS);
    assign inh_halt = (mode == CAMD_M_INH) && (op == CAMD_OP_HALT);
    assign is_jrle = (mode == CAMD_M_IMM) && (op == CAMD_OP_JRLE);

    // ****************************************
    // address adder
    // ****************************************
    assign eab.mode = mode;
    assign eab.idx_y = opcode_r[CAMD_IDX_SEL_BIT];
    assign eab.x = idx_x;
    assign eab.y = idx_y;
    assign eab.operand = operand_r;

    camd_ea_calc u_ea (
        .eab(eab)
    );

    // wake source may come from an unclocked pin, so two flops first
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_req;
            wake_s2_r <= wake_s1_r;
        end
    end

    // ****************************************
    // fetch sequencer
    // ****************************************
    // a read is held until acked; memory latency is therefore free
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= CAMD_S_OPC;
            pc_r <= CAMD_PC_RST;
            addr_r <= CAMD_PC_RST;
            rd_r <= 1'b1;
            opcode_r <= 8'h00;
            operand_r <= 16'h0000;
            ptr_r <= 8'h00;
            len_r <= 2'd0;
        end else begin
            case (state_r)
                CAMD_S_OPC: begin
                    if (mem_ack) begin
                        opcode_r <= mem_rdata;
                        operand_r <= 16'h0000;
                        pc_r <= pc_r + 16'd1;
                        addr_r <= pc_r + 16'd1;
                        len_r <= 2'd1;
                        case (mem_rdata[CAMD_MODE_MSB:CAMD_MODE_LSB])
                            CAMD_M_IMM, CAMD_M_DIR_S, CAMD_M_DIR_L, CAMD_M_IDX_S,
                            CAMD_M_IDX_L, CAMD_M_IND_S, CAMD_M_IND_L: begin
                                state_r <= CAMD_S_OP1;
                            end
                            default: begin
                                rd_r <= 1'b0;
                                state_r <= CAMD_S_EXEC;
                            end
                        endcase
                    end
                end
                CAMD_S_OP1: begin
                    if (mem_ack) begin
                        operand_r <= {8'h00, mem_rdata};
                        pc_r <= pc_r + 16'd1;
                        len_r <= 2'd2;
                        if (mode == CAMD_M_DIR_L || mode == CAMD_M_IDX_L) begin
                            addr_r <= pc_r + 16'd1;
                            state_r <= CAMD_S_OP2;
                        end else if (mode == CAMD_M_IND_S || mode == CAMD_M_IND_L) begin
                            ptr_r <= mem_rdata;
                            addr_r <= {8'h00, mem_rdata};
                            state_r <= CAMD_S_PT1;
                        end else begin
                            rd_r <= 1'b0;
                            state_r <= CAMD_S_EXEC;
                        end
                    end
                end
                CAMD_S_OP2: begin
                    if (mem_ack) begin
                        operand_r <= {operand_r[7:0], mem_rdata};
                        pc_r <= pc_r + 16'd1;
                        len_r <= 2'd3;
                        rd_r <= 1'b0;
                        state_r <= CAMD_S_EXEC;
                    end
                end
                CAMD_S_PT1: begin
                    if (mem_ack) begin
                        operand_r <= {8'h00, mem_rdata};
                        if (mode == CAMD_M_IND_L) begin
                            addr_r <= {8'h00, ptr_r + 8'd1}; // pointer stays in page zero
                            state_r <= CAMD_S_PT2;
                        end else begin
                            rd_r <= 1'b0;
                            state_r <= CAMD_S_EXEC;
                        end
                    end
                end
                CAMD_S_PT2: begin
                    if (mem_ack) begin
                        operand_r <= {operand_r[7:0], mem_rdata};
                        rd_r <= 1'b0;
                        state_r <= CAMD_S_EXEC;
                    end
                end
                CAMD_S_EXEC: begin
                    if (inh_halt) begin
                        state_r <= CAMD_S_HALT;
                    end else begin
                        if (is_jrle && (carry_flag || zero_flag)) begin
                            pc_r <= pc_r + {{8{operand_r[7]}}, operand_r[7:0]};
                            addr_r <= pc_r + {{8{operand_r[7]}}, operand_r[7:0]};
                        end else begin
                            addr_r <= pc_r;
                        end
                        rd_r <= 1'b1;
                        state_r <= CAMD_S_OPC;
                    end
                end
                CAMD_S_HALT: begin
                    if (wake_s2_r) begin
                        addr_r <= pc_r;
                        rd_r <= 1'b1;
                        state_r <= CAMD_S_OPC;
                    end
                end
                default: begin
                    state_r <= CAMD_S_OPC;
                    rd_r <= 1'b1;
                    addr_r <= pc_r;
                end
            endcase
        end
    end

    // ****************************************
    // execution results
    // ****************************************
    // done pulse carries the address and length of the finished instruction
    always_ff @(posedge core_clk) begin
        if (srst) begin
            done_r <= 1'b0;
            ea_r <= 16'h0000;
            taken_r <= 1'b0;
        end else begin
            done_r <= (state_r == CAMD_S_EXEC);
            if (state_r == CAMD_S_EXEC) begin
                ea_r <= eab.ea;
                taken_r <= is_jrle && (carry_flag || zero_flag);
            end
        end
    end

    // mask level starts at level 3 so nothing interrupts before software allows it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mask_r <= CAMD_MASK_RST;
        end else if (state_r == CAMD_S_EXEC && inh_int_en) begin
            mask_r <= CAMD_LVL0;
        end else if (state_r == CAMD_S_EXEC && inh_int_dis) begin
            mask_r <= CAMD_LVL3;
        end
    end

    // oscillator stop follows the halt state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stop_r <= 1'b0;
        end else if (state_r == CAMD_S_EXEC && inh_halt) begin
            stop_r <= 1'b1;
        end else if (state_r == CAMD_S_HALT && wake_s2_r) begin
            stop_r <= 1'b0;
        end
    end

    assign mem_addr = addr_r;
    assign mem_rd = rd_r;
    assign pc = pc_r;
    assign opcode = opcode_r;
    assign operand = operand_r;
    assign eff_addr = ea_r;
    assign instr_len = len_r;
    assign instr_done = done_r;
    assign interrupt_mask_level = mask_r;
    assign branch_taken = taken_r;
    assign osc_stop = stop_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_opc_taken;
        state_r == CAMD_S_OPC && mem_ack;
    endsequence
    sequence s_op1_taken;
        state_r == CAMD_S_OP1 && mem_ack;
    endsequence

    property p_inh_len;
        done_r && mode == CAMD_M_INH |-> len_r == 2'd1;
    endproperty
    a_inh_len: assert property (p_inh_len) else $error("inherent length not one");
    property p_imm_len;
        done_r && mode == CAMD_M_IMM |-> len_r == 2'd2 && operand_r[15:8] == 8'h00;
    endproperty
    a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");
    property p_dir_s;
        done_r && mode == CAMD_M_DIR_S |-> ea_r[15:8] == 8'h00 && ea_r == operand_r;
    endproperty
    a_dir_s: assert property (p_dir_s) else $error("short direct out of page");
    property p_dir_l;
        done_r && mode == CAMD_M_DIR_L |-> len_r == 2'd3 && ea_r == operand_r;
    endproperty
    a_dir_l: assert property (p_dir_l) else $error("long direct wrong");
    property p_idx_n;
        done_r && mode == CAMD_M_IDX_N |-> len_r == 2'd1 && ea_r[15:8] == 8'h00;
    endproperty
    a_idx_n: assert property (p_idx_n) else $error("no-offset index wrong");
    property p_idx_s;
        done_r && mode == CAMD_M_IDX_S |-> ea_r <= 16'h01fe && len_r == 2'd2
            && ea_r == ({8'h00, $past(opcode_r[CAMD_IDX_SEL_BIT] ? idx_y : idx_x)}
            + {8'h00, operand_r[7:0]});
    endproperty
    a_idx_s: assert property (p_idx_s) else $error("short index out of range");
    property p_int_en;
        state_r == CAMD_S_EXEC && inh_int_en |=> mask_r == CAMD_LVL0 && done_r;
    endproperty
    a_int_en: assert property (p_int_en) else $error("enable did not set level 0");
    property p_int_dis;
        state_r == CAMD_S_EXEC && inh_int_dis |=> mask_r == CAMD_LVL3 && done_r;
    endproperty
    a_int_dis: assert property (p_int_dis) else $error("disable did not set level 3");
    property p_jrle;
        done_r && is_jrle |-> taken_r == ($past(carry_flag) || $past(zero_flag))
            && (taken_r ? pc_r == $past(pc_r) + {{8{operand_r[7]}}, operand_r[7:0]}
            : pc_r == $past(pc_r));
    endproperty
    a_jrle: assert property (p_jrle) else $error("jump condition wrong");
    property p_halt;
        stop_r && !wake_s2_r |=> stop_r && !rd_r;
    endproperty
    a_halt: assert property (p_halt) else $error("left halt without wake");
    property p_pc_adv;
        s_opc_taken or s_op1_taken |=> pc_r == $past(pc_r) + 16'd1;
    endproperty
    a_pc_adv: assert property (p_pc_adv) else $error("pc did not advance");
endmodule

// *** verification/camd_mem_model.sv ***
// Purpose: program and data memory answering the core's byte reads
// Assumes: one read held by the core until acknowledged
// Notes: lat sets extra wait cycles; bench fills mem by hierarchy
`timescale 1ns/1ps
module camd_mem_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [3:0] lat,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    // ****************************************
    // storage and read handshake
    // ****************************************
    logic [7:0] mem [0:65535];
    logic [3:0] wait_r;

    // ack is a one-cycle pulse; data outside it is scrambled so a late sample shows
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_ack <= 1'b0;
            wait_r <= 4'h0;
            mem_rdata <= 8'h5a;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            wait_r <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_rd && wait_r >= lat) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
        end else begin
            wait_r <= mem_rd ? wait_r + 4'h1 : 4'h0; // slow answer
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// *** verification/test_cpu_addressing_mode_decoder.sv ***
// Purpose: self-checking bench for fetch, decode and address forming
// Assumes: one program from address 0 walks every addressing mode
// Notes: outputs sampled on the falling edge, inputs driven on the rising edge
`timescale 1ns/1ps
module test_cpu_addressing_mode_decoder import camd_pkg::*; ;
    // ****************************************
    // stimulus, design and memory
    // ****************************************
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic carry_flag = 1'b0;
    logic zero_flag = 1'b0;
    logic wake_req = 1'b0;
    logic [7:0] idx_x = 8'h80;
    logic [7:0] idx_y = 8'hff;
    logic [3:0] lat = 4'h0;
    logic mem_ack, mem_rd, instr_done, branch_taken, osc_stop;
    logic [7:0] mem_rdata, opcode;
    logic [15:0] mem_addr, pc, operand, eff_addr;
    logic [1:0] instr_len, interrupt_mask_level;
    int n_fail = 0;
    int n_tests = 0;

    always #50 core_clk = ~core_clk;

    camd_core uut (.core_clk, .srst, .mem_rdata, .mem_ack, .idx_x, .idx_y, .carry_flag,
        .zero_flag, .wake_req, .mem_addr, .mem_rd, .pc, .opcode, .operand, .eff_addr,
        .instr_len, .instr_done, .interrupt_mask_level, .branch_taken, .osc_stop);
    camd_mem_model u_mem (.core_clk, .srst, .mem_addr, .mem_rd, .lat, .mem_ack, .mem_rdata);

    // ****************************************
    // shared checks
    // ****************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // bounded wait, so a stuck fetch ends the scenario instead of the run
    task automatic wait_done();
        int i;
        for (i = 0; i < 60; i++) begin
            @(negedge core_clk);
            if (instr_done === 1'b1) break;
        end
        if (i == 60) begin
            n_fail++;
            $display("mismatch %0t no instr_done", $time);
        end
    endtask

    // next fetch address shows where pc went after the operand bytes
    task automatic step(input logic [15:0] nxt, input logic [1:0] len);
        wait_done();
        chk16({14'h0, instr_len}, {14'h0, len}, "length");
        chk16(mem_addr, nxt, "next fetch");
        chk16(pc, nxt, "pc after operands");
    endtask

    task automatic load();
        logic [7:0] p [36];
        p = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h5a, 8'h20, 8'hc3, 8'h30, 8'h12, 8'h34,
              8'h40, 8'h58, 8'hff, 8'h60, 8'hff, 8'hf0, 8'h70, 8'h80, 8'h80, 8'hff,
              8'h17, 8'h04, 8'h17, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h02,
              8'h00, 8'h00, 8'h17, 8'hfe, 8'h01, 8'h90};
        for (int i = 0; i < 36; i++) u_mem.mem[i] = p[i];
        u_mem.mem[16'h0080] = 8'h9c;
        u_mem.mem[16'h00ff] = 8'hab;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk16(pc, CAMD_PC_RST, "reset pc");
        chk16(mem_addr, 16'h0000, "reset fetch");
        chk1(mem_rd, 1'b1, "reset read");
        chk16({14'h0, interrupt_mask_level}, {14'h0, CAMD_MASK_RST}, "reset mask");
    endtask

    task automatic t_inherent();
        step(16'h0001, 2'h1);
        step(16'h0002, 2'h1);
        chk16({14'h0, interrupt_mask_level}, {14'h0, CAMD_LVL0}, "enable mask");
        step(16'h0003, 2'h1);
        chk16({14'h0, interrupt_mask_level}, {14'h0, CAMD_LVL3}, "disable mask");
    endtask

    task automatic t_direct();
        step(16'h0005, 2'h2);
        chk16(operand, 16'h005a, "immediate value");
        step(16'h0007, 2'h2);
        chk16(eff_addr, 16'h00c3, "short direct");
        step(16'h000a, 2'h3);
        chk16(eff_addr, 16'h1234, "long direct order");
        chk16({8'h00, opcode}, 16'h0030, "long direct opcode");
    endtask

    task automatic t_indexed();
        step(16'h000b, 2'h1);
        chk16(eff_addr, 16'h0080, "index alone");
        step(16'h000d, 2'h2);
        chk16(eff_addr, 16'h01fe, "short indexed top");
        step(16'h0010, 2'h3);
        chk16(eff_addr, 16'h0070, "long indexed wrap");
    endtask

    // slow memory here: pointer reads must wait for each acknowledge
    task automatic t_indirect();
        @(posedge core_clk) lat <= 4'h2;
        step(16'h0012, 2'h2);
        chk16(eff_addr, 16'h009c, "short pointer");
        step(16'h0014, 2'h2);
        chk16(eff_addr, 16'hab00, "long pointer wrap");
        @(posedge core_clk) lat <= 4'h0;
    endtask

    task automatic t_branch();
        step(16'h0016, 2'h2);
        chk1(branch_taken, 1'b0, "no flags");
        @(posedge core_clk) zero_flag <= 1'b1;
        step(16'h001c, 2'h2);
        chk1(branch_taken, 1'b1, "zero only");
        @(posedge core_clk) begin
            zero_flag <= 1'b0;
            carry_flag <= 1'b1;
        end
        step(16'h0020, 2'h2);
        chk1(branch_taken, 1'b1, "carry only");
        @(posedge core_clk) zero_flag <= 1'b1;
        step(16'h0020, 2'h2);
        chk1(branch_taken, 1'b1, "both flags backward");
        @(posedge core_clk) begin
            zero_flag <= 1'b0;
            carry_flag <= 1'b0;
        end
        step(16'h0022, 2'h2);
        chk1(branch_taken, 1'b0, "flags cleared");
    endtask

    task automatic t_halt();
        wait_done();
        chk1(osc_stop, 1'b1, "halt stops");
        repeat (10) @(negedge core_clk);
        chk1(mem_rd, 1'b0, "no fetch while halted");
        chk1(osc_stop, 1'b1, "stays halted");
        @(posedge core_clk) wake_req <= 1'b1;
        for (int i = 0; i < 8 && mem_rd !== 1'b1; i++) @(negedge core_clk);
        chk1(osc_stop, 1'b0, "woken");
        chk16(mem_addr, 16'h0023, "resume fetch");
        @(posedge core_clk) wake_req <= 1'b0;
        step(16'h0024, 2'h1);
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic conclude();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        load();
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_inherent();
        t_direct();
        t_indexed();
        t_indirect();
        t_branch();
        t_halt();
        conclude();
    end

    // the program needs some 150 cycles; this is a generous ceiling
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        $display("mismatch %0t watchdog expired", $time);
        conclude();
    end
endmodule
